// >>> flag_stack_model.sv
// Stack memory model holding the last pushed flag image
`timescale 1ns/10ps
`default_nettype none
module flag_stack_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Push side of the unit
  input wire flag_unit_pkg::flag_rsp_t rsp,
  // Top of stack
  output logic [63:0] top_r
);
  // Empty stack reads a fixed pattern, never a plausible image
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_r <= 64'h5555_5555_5555_5555;
    end else if (rsp.push_valid) begin
      top_r <= rsp.push_data;
    end
  end
endmodule
`default_nettype wire

// >>> flag_unit_assertions.sv
// Port-level checker for the status flag control unit
`timescale 1ns/10ps
`default_nettype none
module flag_unit_assertions #(
  parameter int IDX_W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic req_valid,
  input wire flag_unit_pkg::flag_req_t req,
  input wire flag_unit_pkg::cpu_ctx_t ctx,
  input wire logic src_load,
  input wire logic [IDX_W-1:0] source_index_register,
  input wire flag_unit_pkg::flag_rsp_t rsp,
  input wire logic [flag_unit_pkg::FLAG_W-1:0] status_flag_register,
  input wire logic [flag_unit_pkg::WIDE_W-1:0] status_flag_register64,
  input wire logic irq_pending,
  input wire logic maskable_irq_input
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_op(flag_unit_pkg::flag_op_t o);
    req_valid && req.op == o;
  endsequence
  a_invert_carry: assert property (s_op(flag_unit_pkg::OP_INVERT_CARRY)
    |=> status_flag_register == ($past(status_flag_register) ^ 32'h0000_0001))
    else $error("invert carry touched wrong bits");
  a_set_dir: assert property (s_op(flag_unit_pkg::OP_SET_DIR)
    |=> status_flag_register == ($past(status_flag_register) | 32'h0000_0400))
    else $error("set direction wrong");
  a_byte_keep: assert property (s_op(flag_unit_pkg::OP_FLAGS_TO_BYTE)
    |=> $stable(status_flag_register)
    && (rsp.accum_upper_byte & 8'h2A) == ($past(req.accum_upper_byte) & 8'h2A))
    else $error("flags to byte changed kept bits");
  a_push_narrow: assert property (s_op(flag_unit_pkg::OP_PUSH_NARROW)
    |=> rsp.push_valid && rsp.push_data == {48'h0000_0000_0000, status_flag_register[15:0]})
    else $error("narrow push image wrong");
  a_push_hide: assert property (s_op(flag_unit_pkg::OP_PUSH_WIDE)
    |=> rsp.push_valid && rsp.push_data[17:16] == 2'h0)
    else $error("wide push shows hidden bits");
  a_upper_zero: assert property (
    status_flag_register64 == {32'h0000_0000, status_flag_register})
    else $error("wide flag view wrong");
  a_done_pulse: assert property (1'b1 |=> rsp.done == $past(req_valid))
    else $error("done does not follow request");
  a_irq_masked: assert property (!status_flag_register[9] [*2] |-> !irq_pending)
    else $error("interrupt pending while masked");
  // Four idle pin samples cover the three sync stages and the level register
  a_irq_quiet: assert property (!maskable_irq_input [*4] |=> !irq_pending)
    else $error("interrupt pending with pin idle");
  a_byte_refuse: assert property (s_op(flag_unit_pkg::OP_BYTE_TO_FLAGS)
    ##0 ctx.long_mode && !ctx.byte_flags_supported
    |=> rsp.fault && $stable(status_flag_register))
    else $error("byte transfer not refused");
  a_irq_refuse: assert property (req_valid
    && req.op == flag_unit_pkg::OP_CLEAR_IRQ_EN && ctx.protected_mode && !ctx.v86_mode
    && ctx.current_priv_level > status_flag_register[13:12]
    |=> rsp.fault && $stable(status_flag_register))
    else $error("privileged clear not refused");
  a_step_up: assert property (s_op(flag_unit_pkg::OP_STRING_STEP)
    ##0 !status_flag_register[10] && !src_load
    |=> source_index_register == $past(source_index_register) + $past(req.elem_bytes))
    else $error("index did not step up");
endmodule
`default_nettype wire

// >>> flag_unit_pkg.sv
// Shared constants and types for the status flag control unit
package flag_unit_pkg;

  localparam int FLAG_W = 32;
  localparam int WIDE_W = 64;
  localparam int IDX_W = 32;

  // Flag bit positions
  localparam int CARRY_BIT = 0;
  localparam int PARITY_BIT = 2;
  localparam int AUX_BIT = 4;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 7;
  localparam int TRAP_BIT = 8;
  localparam int IRQ_EN_BIT = 9;
  localparam int DIR_BIT = 10;
  localparam int OVF_BIT = 11;
  localparam int IO_PRIVILEGE_FIELD_LO_BIT = 12;
  localparam int IO_PRIVILEGE_FIELD_HI_BIT = 13;
  localparam int RESUME_BIT = 16;
  localparam int V86_BIT = 17;
  localparam int ALIGN_BIT = 18;
  localparam int PROBE_BIT = 21;
  localparam int FIXED_ONE_BIT = 1;

  // Bits a narrow pop always writes: 11,10,8,7,6,4,2,0
  localparam logic [31:0] POP_NARROW_MASK = 32'h0000_0DD5;
  // Extra bits a wide pop writes: 18 and 21
  localparam logic [31:0] POP_WIDE_EXTRA_MASK = 32'h0024_0000;
  localparam logic [31:0] IO_PRIVILEGE_FIELD_MASK = 32'h0000_3000;
  localparam logic [31:0] IRQ_EN_MASK = 32'h0000_0200;
  // Resume and virtual-8086 bits hidden in a wide push image
  localparam logic [31:0] PUSH_HIDE_MASK = 32'h0003_0000;
  // Status bits moved to and from the accumulator upper byte: 7,6,4,2,0
  localparam logic [7:0] BYTE_FLAG_MASK = 8'hD5;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0002;
  localparam logic [31:0] FIXED_ONE = 32'h0000_0002;
  localparam logic [1:0] PRIV_TOP = 2'h0;
  localparam logic [63:0] LOW_WORD_MASK = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] LOW_DWORD_MASK = 64'h0000_0000_FFFF_FFFF;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_SET_CARRY,
    OP_CLEAR_CARRY,
    OP_INVERT_CARRY,
    OP_SET_DIR,
    OP_CLEAR_DIR,
    OP_FLAGS_TO_BYTE,
    OP_BYTE_TO_FLAGS,
    OP_PUSH_NARROW,
    OP_PUSH_WIDE,
    OP_POP_NARROW,
    OP_POP_WIDE,
    OP_SET_IRQ_EN,
    OP_CLEAR_IRQ_EN,
    OP_STRING_STEP
  } flag_op_t;

  // Operation request from the pipeline
  typedef struct packed {
    flag_op_t op;
    logic [7:0] accum_upper_byte;
    logic [63:0] pop_data;
    logic [3:0] elem_bytes;
  } flag_req_t;

  // Processor context the request executes in
  typedef struct packed {
    logic long_mode;
    logic protected_mode;
    logic v86_mode;
    logic [1:0] current_priv_level;
    logic byte_flags_supported;
  } cpu_ctx_t;

  // Result returned to the pipeline
  typedef struct packed {
    logic done;
    logic fault;
    logic [7:0] accum_upper_byte;
    logic push_valid;
    logic [63:0] push_data;
    logic [1:0] push_size;
  } flag_rsp_t;

  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  localparam logic [1:0] SIZE_QWORD = 2'h3;

endpackage

// >>> index_stepper.sv
// Source and destination index stepping for string operations
`timescale 1ns/10ps
`default_nettype none
module index_stepper #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic step,
  input wire logic direction_flag,
  input wire logic [3:0] elem_bytes,
  // Value
  output logic [W-1:0] index_r
);

  logic [W-1:0] delta;

  assign delta = W'(elem_bytes);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      index_r <= '0;
    end else if (load) begin
      index_r <= load_value;
    end else if (step) begin
      // Down when direction is set, up when clear
      if (direction_flag) begin
        index_r <= index_r - delta; // RQ3
      end else begin
        index_r <= index_r + delta; // RQ3
      end
    end
  end

endmodule
`default_nettype wire

// >>> status_flag_control_unit.sv
// Status flag register and the instructions that read and write it
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RQ1: Set, clear and invert carry change only the carry flag.
// RQ2: Set and clear direction change only the direction flag.
// RQ3: Index registers step up when direction clear, down when set.
// RQ4: Flags-to-byte copies sign, zero, aux, parity, carry to bits 7,6,4,2,0.
// RQ5: Flags-to-byte keeps byte bits 5,3,1 and leaves flags unchanged.
// RQ6: Byte-to-flags loads sign, zero, aux, parity, carry from bits 7,6,4,2,0.
// RQ7: Narrow push writes only the low word of the flags.
// RQ8: Wide push writes all flags with resume and virtual-8086 shown zero.
// RQ9: Narrow pop always writes bits 11,10,8,7,6,4,2,0 only.
// RQ10: Pop writes the privilege field only at privilege level zero.
// RQ11: Pop writes interrupt enable only when privilege field >= current level.
// RQ12: Wide pop also writes bits 18 and 21 with same restrictions.
// RQ13: Interrupt enable set/clear ops; set lets maskable interrupts through.
// RQ14: Interrupt enable ops allowed or refused by mode and privilege.
// RQ15: In 64-bit mode byte transfers need the feature query bit.
// RQ16: Narrow push and pop behave the same in 64-bit mode.
// RQ17: In 64-bit mode wide push writes full 64-bit flags image.
// RQ18: In 64-bit mode wide pop loads low 32 bits, zeroes upper bits.
// RQ19: Repeated string ops step indexes after each element by direction.
// RQ20: Bits a pop may not change keep their previous values silently.
// RQ21: Modified flags are visible to the next instruction.
module status_flag_control_unit #(
  parameter int IDX_W = flag_unit_pkg::IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request from the pipeline
  input wire logic req_valid,
  input wire flag_unit_pkg::flag_req_t req,
  input wire flag_unit_pkg::cpu_ctx_t ctx,
  // Index register loads
  input wire logic src_load,
  input wire logic [IDX_W-1:0] src_load_value,
  input wire logic dst_load,
  input wire logic [IDX_W-1:0] dst_load_value,
  // Maskable interrupt pin
  input wire logic maskable_irq_input,
  // Results
  output flag_unit_pkg::flag_rsp_t rsp,
  output logic [flag_unit_pkg::FLAG_W-1:0] status_flag_register,
  output logic [flag_unit_pkg::WIDE_W-1:0] status_flag_register64,
  output logic [IDX_W-1:0] source_index_register,
  output logic [IDX_W-1:0] dest_index_register,
  output logic irq_pending
);

  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  flag_unit_pkg::flag_rsp_t rsp_r;
  flag_unit_pkg::flag_rsp_t rsp_nxt;
  logic [2:0] irq_sync_r;
  logic irq_level_r;
  logic [31:0] pop_mask;
  logic [31:0] pop_word;
  logic [1:0] io_privilege_field;
  logic irq_op_allowed;
  logic byte_ops_allowed;
  logic string_step;

  assign io_privilege_field = flags_r[flag_unit_pkg::IO_PRIVILEGE_FIELD_HI_BIT:flag_unit_pkg::IO_PRIVILEGE_FIELD_LO_BIT];

  // Interrupt enable ops: real mode always; protected needs level <= field;
  // virtual-8086 needs field at its top value
  always_comb begin
    if (ctx.v86_mode) begin
      irq_op_allowed = (io_privilege_field == 2'h3); // RQ14
    end else if (ctx.protected_mode || ctx.long_mode) begin
      irq_op_allowed = (ctx.current_priv_level <= io_privilege_field); // RQ14
    end else begin
      irq_op_allowed = 1'b1;
    end
  end

  // Outside 64-bit mode the byte transfers never fault
  assign byte_ops_allowed = !ctx.long_mode || ctx.byte_flags_supported; // RQ15

  // Which bits a pop may write, given privilege
  always_comb begin
    pop_mask = flag_unit_pkg::POP_NARROW_MASK; // RQ9
    if (req.op == flag_unit_pkg::OP_POP_WIDE) begin
      pop_mask = pop_mask | flag_unit_pkg::POP_WIDE_EXTRA_MASK; // RQ12
    end
    if (ctx.current_priv_level == flag_unit_pkg::PRIV_TOP) begin
      pop_mask = pop_mask | flag_unit_pkg::IO_PRIVILEGE_FIELD_MASK; // RQ10
    end
    if (io_privilege_field >= ctx.current_priv_level) begin
      pop_mask = pop_mask | flag_unit_pkg::IRQ_EN_MASK; // RQ11
    end
  end

  // Narrow pop only sees a word; upper pop bits beyond 32 are dropped
  always_comb begin
    if (req.op == flag_unit_pkg::OP_POP_NARROW) begin
      pop_word = 32'(req.pop_data & flag_unit_pkg::LOW_WORD_MASK); // RQ16
    end else begin
      pop_word = 32'(req.pop_data & flag_unit_pkg::LOW_DWORD_MASK); // RQ18
    end
  end

  always_comb begin
    flags_nxt = flags_r;
    rsp_nxt = '0;
    if (req_valid) begin
      rsp_nxt.done = 1'b1;
      rsp_nxt.accum_upper_byte = req.accum_upper_byte;
      unique case (req.op)
        flag_unit_pkg::OP_SET_CARRY: begin
          flags_nxt[flag_unit_pkg::CARRY_BIT] = 1'b1; // RQ1
        end
        flag_unit_pkg::OP_CLEAR_CARRY: begin
          flags_nxt[flag_unit_pkg::CARRY_BIT] = 1'b0; // RQ1
        end
        flag_unit_pkg::OP_INVERT_CARRY: begin
          flags_nxt[flag_unit_pkg::CARRY_BIT] = !flags_r[flag_unit_pkg::CARRY_BIT]; // RQ1
        end
        flag_unit_pkg::OP_SET_DIR: begin
          flags_nxt[flag_unit_pkg::DIR_BIT] = 1'b1; // RQ2
        end
        flag_unit_pkg::OP_CLEAR_DIR: begin
          flags_nxt[flag_unit_pkg::DIR_BIT] = 1'b0; // RQ2
        end
        flag_unit_pkg::OP_FLAGS_TO_BYTE: begin
          if (byte_ops_allowed) begin
            // Unlisted byte bits pass through, flags stay put
            rsp_nxt.accum_upper_byte = (req.accum_upper_byte & ~flag_unit_pkg::BYTE_FLAG_MASK)
              | (flags_r[7:0] & flag_unit_pkg::BYTE_FLAG_MASK); // RQ4 RQ5
          end else begin
            rsp_nxt.fault = 1'b1; // RQ15
          end
        end
        flag_unit_pkg::OP_BYTE_TO_FLAGS: begin
          if (byte_ops_allowed) begin
            flags_nxt[7:0] = (flags_r[7:0] & ~flag_unit_pkg::BYTE_FLAG_MASK)
              | (req.accum_upper_byte & flag_unit_pkg::BYTE_FLAG_MASK); // RQ6
          end else begin
            rsp_nxt.fault = 1'b1; // RQ15
          end
        end
        flag_unit_pkg::OP_PUSH_NARROW: begin
          rsp_nxt.push_valid = 1'b1;
          rsp_nxt.push_data = 64'(flags_r) & flag_unit_pkg::LOW_WORD_MASK; // RQ7 RQ16
          rsp_nxt.push_size = flag_unit_pkg::SIZE_WORD;
        end
        flag_unit_pkg::OP_PUSH_WIDE: begin
          rsp_nxt.push_valid = 1'b1;
          rsp_nxt.push_data = 64'(flags_r & ~flag_unit_pkg::PUSH_HIDE_MASK); // RQ8 RQ17
          rsp_nxt.push_size = ctx.long_mode ? flag_unit_pkg::SIZE_QWORD
                                            : flag_unit_pkg::SIZE_DWORD; // RQ17
        end
        flag_unit_pkg::OP_POP_NARROW, flag_unit_pkg::OP_POP_WIDE: begin
          // Bits outside the mask keep old values without a fault
          flags_nxt = (flags_r & ~pop_mask) | (pop_word & pop_mask); // RQ9 RQ20
        end
        flag_unit_pkg::OP_SET_IRQ_EN: begin
          if (irq_op_allowed) begin
            flags_nxt[flag_unit_pkg::IRQ_EN_BIT] = 1'b1; // RQ13
          end else begin
            rsp_nxt.fault = 1'b1; // RQ14
          end
        end
        flag_unit_pkg::OP_CLEAR_IRQ_EN: begin
          if (irq_op_allowed) begin
            flags_nxt[flag_unit_pkg::IRQ_EN_BIT] = 1'b0; // RQ13
          end else begin
            rsp_nxt.fault = 1'b1; // RQ14
          end
        end
        flag_unit_pkg::OP_STRING_STEP, flag_unit_pkg::OP_NONE: begin
        end
        default: begin
          rsp_nxt.fault = 1'b1;
        end
      endcase
    end
    flags_nxt = flags_nxt | flag_unit_pkg::FIXED_ONE;
  end

  // Flags update at the end of the cycle so the next op sees them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_r <= flag_unit_pkg::FLAG_RESET;
    end else begin
      flags_r <= flags_nxt; // RQ21
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // Pin input: three stages, change accepted when last two agree
  // Reset clears the stages to the idle pin level, so no false request follows reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_sync_r <= '0;
    end else begin
      irq_sync_r <= {irq_sync_r[1:0], maskable_irq_input};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_level_r <= 1'b0;
    end else if (irq_sync_r[1] == irq_sync_r[2]) begin
      irq_level_r <= irq_sync_r[2];
    end
  end

  // One step per element, every element of a repeated op included
  assign string_step = req_valid && (req.op == flag_unit_pkg::OP_STRING_STEP); // RQ19

  index_stepper #(.W(IDX_W)) u_src_index (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(src_load),
    .load_value(src_load_value),
    .step(string_step),
    .direction_flag(flags_r[flag_unit_pkg::DIR_BIT]),
    .elem_bytes(req.elem_bytes),
    .index_r(source_index_register)
  );

  index_stepper #(.W(IDX_W)) u_dst_index (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(dst_load),
    .load_value(dst_load_value),
    .step(string_step),
    .direction_flag(flags_r[flag_unit_pkg::DIR_BIT]),
    .elem_bytes(req.elem_bytes),
    .index_r(dest_index_register)
  );

  assign rsp = rsp_r;
  assign status_flag_register = flags_r;
  // Upper half always zero
  assign status_flag_register64 = 64'(flags_r); // RQ18
  assign irq_pending = irq_level_r && flags_r[flag_unit_pkg::IRQ_EN_BIT]; // RQ13

endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the status flag control unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  flag_unit_pkg::flag_req_t req = '0;
  flag_unit_pkg::cpu_ctx_t ctx = '0;
  logic src_load = 1'b0;
  logic dst_load = 1'b0;
  logic [31:0] src_val = '0;
  logic [31:0] dst_val = '0;
  logic irq_in = 1'b0;
  flag_unit_pkg::flag_rsp_t rsp;
  flag_unit_pkg::flag_rsp_t seen;
  logic [31:0] flags;
  logic [63:0] flags64;
  logic [31:0] src_idx;
  logic [31:0] dst_idx;
  logic irq_pending;
  logic [63:0] stack_top;
  int error_cnt = 0;
  int checks_done = 0;
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  status_flag_control_unit i_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .ctx(ctx), .src_load(src_load), .src_load_value(src_val),
    .dst_load(dst_load), .dst_load_value(dst_val), .maskable_irq_input(irq_in),
    .rsp(rsp), .status_flag_register(flags), .status_flag_register64(flags64),
    .source_index_register(src_idx), .dest_index_register(dst_idx),
    .irq_pending(irq_pending));
  flag_stack_model i_stack (.sys_clk(sys_clk), .rst(rst), .rsp(rsp), .top_r(stack_top));
  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One idle cycle between requests keeps each strobe a single pulse
  task automatic run(input flag_unit_pkg::flag_op_t o, input logic [7:0] b,
    input logic [63:0] d);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req.op = o;
    req.accum_upper_byte = b;
    req.pop_data = d;
    @(negedge sys_clk);
    req_valid = 1'b0;
    seen = rsp;
    chk("done", seen.done, 1'b1);
  endtask
  task automatic t_carry();
    flag_unit_pkg::flag_op_t ops[5] = '{flag_unit_pkg::OP_SET_CARRY,
      flag_unit_pkg::OP_INVERT_CARRY, flag_unit_pkg::OP_INVERT_CARRY,
      flag_unit_pkg::OP_SET_DIR, flag_unit_pkg::OP_CLEAR_CARRY};
    logic [31:0] exp[5] = '{32'h0000_0003, 32'h0000_0002, 32'h0000_0003,
      32'h0000_0403, 32'h0000_0402};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], 8'h00, '0);
      chk("flags", flags, exp[i]);
    end
    $display("test carry finished");
  endtask
  task automatic t_dir();
    @(negedge sys_clk);
    src_load = 1'b1;
    dst_load = 1'b1;
    src_val = 32'h0000_0100;
    dst_val = 32'h0000_0200;
    @(negedge sys_clk);
    src_load = 1'b0;
    dst_load = 1'b0;
    req.elem_bytes = 4'h4;
    run(flag_unit_pkg::OP_STRING_STEP, 8'h00, '0);
    run(flag_unit_pkg::OP_STRING_STEP, 8'h00, '0);
    chk("src", src_idx, 32'h0000_00F8);
    chk("dst", dst_idx, 32'h0000_01F8);
    run(flag_unit_pkg::OP_CLEAR_DIR, 8'h00, '0);
    chk("flags", flags, 32'h0000_0002);
    req.elem_bytes = 4'h2;
    run(flag_unit_pkg::OP_STRING_STEP, 8'h00, '0);
    chk("src", src_idx, 32'h0000_00FA);
    chk("dst", dst_idx, 32'h0000_01FA);
    $display("test direction finished");
  endtask
  task automatic t_bytes();
    run(flag_unit_pkg::OP_BYTE_TO_FLAGS, 8'h41, '0);
    chk("flags", flags, 32'h0000_0043);
    run(flag_unit_pkg::OP_FLAGS_TO_BYTE, 8'h2A, '0);
    chk("byte", seen.accum_upper_byte, 8'h6B);
    chk("flags", flags, 32'h0000_0043);
    ctx = '{1'b1, 1'b1, 1'b0, 2'h0, 1'b0};
    run(flag_unit_pkg::OP_BYTE_TO_FLAGS, 8'h00, '0);
    chk("fault", seen.fault, 1'b1);
    chk("flags", flags, 32'h0000_0043);
    ctx.byte_flags_supported = 1'b1;
    run(flag_unit_pkg::OP_BYTE_TO_FLAGS, 8'h00, '0);
    chk("flags", flags, 32'h0000_0002);
    $display("test bytes finished");
  endtask
  task automatic t_pop();
    ctx = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1};
    run(flag_unit_pkg::OP_POP_WIDE, 8'h00, 64'hFFFF_FFFF_FFFF_FFFF);
    chk("wide", flags64, 64'h0000_0000_0024_3FD7);
    ctx = '{1'b0, 1'b1, 1'b0, 2'h3, 1'b1};
    run(flag_unit_pkg::OP_POP_NARROW, 8'h00, 64'hFFFF_FFFF_FFFF_0000);
    chk("flags", flags, 32'h0024_3002);
    ctx.current_priv_level = 2'h0;
    run(flag_unit_pkg::OP_POP_WIDE, 8'h00, 64'h0000_0000_0000_1200);
    chk("flags", flags, 32'h0000_1202);
    ctx.current_priv_level = 2'h2;
    run(flag_unit_pkg::OP_POP_NARROW, 8'h00, '0);
    chk("flags", flags, 32'h0000_1202);
    $display("test pop finished");
  endtask
  task automatic t_push();
    ctx = '{1'b1, 1'b1, 1'b0, 2'h0, 1'b1};
    run(flag_unit_pkg::OP_PUSH_NARROW, 8'h00, '0);
    chk("narrow", seen.push_data, 64'h0000_0000_0000_1202);
    chk("narrow size", seen.push_size, 2'h1);
    run(flag_unit_pkg::OP_PUSH_WIDE, 8'h00, '0);
    chk("wide", seen.push_data, 64'h0000_0000_0000_1202);
    chk("wide size", seen.push_size, 2'h3);
    ctx.long_mode = 1'b0;
    run(flag_unit_pkg::OP_PUSH_WIDE, 8'h00, '0);
    chk("size", seen.push_size, 2'h2);
    run(flag_unit_pkg::OP_SET_CARRY, 8'h00, '0);
    run(flag_unit_pkg::OP_POP_WIDE, 8'h00, stack_top);
    chk("flags", flags, 32'h0000_1202);
    $display("test push finished");
  endtask
  task automatic t_irq();
    irq_in = 1'b1;
    for (int i = 0; i < 10 && irq_pending !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    chk("irq", irq_pending, 1'b1);
    if (irq_pending !== 1'b1) begin
      stop_test();
    end
    ctx = '{1'b0, 1'b1, 1'b0, 2'h3, 1'b1};
    run(flag_unit_pkg::OP_CLEAR_IRQ_EN, 8'h00, '0);
    chk("refuse", {seen.fault, flags}, {1'b1, 32'h0000_1202});
    ctx.v86_mode = 1'b1;
    run(flag_unit_pkg::OP_SET_IRQ_EN, 8'h00, '0);
    chk("v86", seen.fault, 1'b1);
    ctx = '{1'b0, 1'b1, 1'b0, 2'h1, 1'b1};
    run(flag_unit_pkg::OP_CLEAR_IRQ_EN, 8'h00, '0);
    chk("allow", {seen.fault, flags}, {1'b0, 32'h0000_1002});
    @(negedge sys_clk);
    chk("masked", irq_pending, 1'b0);
    ctx = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1};
    run(flag_unit_pkg::OP_SET_IRQ_EN, 8'h00, '0);
    chk("flags", flags, 32'h0000_1202);
    $display("test irq finished");
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    ctx = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1};
    t_carry();
    t_dir();
    t_bytes();
    t_pop();
    t_push();
    t_irq();
    stop_test();
  end
endmodule
bind status_flag_control_unit flag_unit_assertions #(.IDX_W(IDX_W)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req), .ctx(ctx),
  .src_load(src_load), .source_index_register(source_index_register), .rsp(rsp),
  .status_flag_register(status_flag_register),
  .status_flag_register64(status_flag_register64), .irq_pending(irq_pending),
  .maskable_irq_input(maskable_irq_input));
`default_nettype wire
